// ### spfr_pkg.sv
// shared types and constants for the pipelined flash read block
package spfr_pkg;
  localparam int          ADDR_W        = 21;
  localparam int          DATA_W        = 16;
  localparam int          SLOTS         = 3;
  localparam logic [2:0]  LAT_RESET     = 3'h4;
  localparam logic [2:0]  LAT_MIN       = 3'h1;
  localparam logic [2:0]  LAT_MAX       = 3'h4;
  localparam int          BANK_BIT      = 1;
  localparam int          BYTE_BIT      = 0;

  typedef struct packed {
    logic              valid;
    logic [2:0]        count;
    logic [ADDR_W-1:0] addr;
    logic              byte_mode;
  } spfr_slot_type;
endpackage

// ### spfr_read_pipe.sv
// synchronous pipelined read front end of a flash array
`timescale 1ns/100ps
// Functional notes
// R1: low strobe at selected edge starts read
// R2: deselected device ignores the strobe
// R3: strobe disregarded during write cycles
// R4: clock ignored for whole write
// R5: data latched after latency clocks
// R6: power-up or power-down exit sets four
// R7: sleep keeps latency setting
// R8: configuration command sets latency one to four
// R9: stopped clock loses no access state
// R10: word address, bit one picks bank
// R11: byte mode uses bit zero
// R12: three reads overlap alternating banks
// R13: two reads overlap same bank
// R14: host spaces same-bank reads by latency
// R15: host keeps both spacing rules
// R16: host matches latency to frequency
// R17: host uses only recommended latencies
// R18: each read keeps its own count
module spfr_read_pipe
  import spfr_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int DATA_WIDTH = DATA_W
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // read request
  input  wire logic                  chip_select,
  input  wire logic                  address_valid_n,
  input  wire logic                  write_active,
  input  wire logic                  byte_mode,
  input  wire logic [ADDR_WIDTH-1:0] addr,
  // latency control
  input  wire logic                  powerdown_n,
  input  wire logic                  cfg_write,
  input  wire logic [2:0]            cfg_latency,
  // array port
  output logic [ADDR_WIDTH-2:0]      array_addr,
  output logic                       array_bank,
  output logic                       array_rd,
  input  wire logic [DATA_WIDTH-1:0] array_data,
  // data outputs
  output logic [DATA_WIDTH-1:0]      read_data,
  output logic                       read_valid,
  output logic [2:0]                 read_latency_setting
);

  spfr_slot_type slot_r   [SLOTS];
  spfr_slot_type slot_nxt [SLOTS];
  logic [2:0]    lat_nxt;
  logic [DATA_WIDTH-1:0] data_nxt;
  logic          done_any;
  logic [1:0]    done_idx;
  logic [1:0]    free_idx;
  logic          free_any;
  logic          start;
  logic          start_ok;
  logic          done_fire;
  logic          cfg_ok;
  logic          next_any;
  logic [1:0]    next_idx;
  logic          addr_load;
  logic [ADDR_WIDTH-2:0] addr_next;

  // read start qualifiers
  assign start = chip_select && !address_valid_n && !write_active; // R1 R2 R3
  assign start_ok  = start && free_any; // R12 R13
  assign done_fire = done_any && !write_active; // R4
  assign cfg_ok    = cfg_write && !write_active
                     && cfg_latency >= LAT_MIN && cfg_latency <= LAT_MAX;

  // array address follows the read that completes next
  assign addr_load = (start_ok && read_latency_setting == LAT_MIN)
                     || (next_any && !write_active);
  assign addr_next = (start_ok && read_latency_setting == LAT_MIN) ?
                     addr[ADDR_WIDTH-1:1] :
                     slot_r[next_idx].addr[ADDR_WIDTH-1:1]; // R18

  // latency setting
  always_comb begin
    lat_nxt = read_latency_setting;
    if (!powerdown_n) begin
      lat_nxt = LAT_RESET; // R6
    end else if (cfg_ok) begin // R4
      lat_nxt = cfg_latency; // R8
    end
  end

  // slot search and per-slot countdown
  always_comb begin
    done_any = 1'b0;
    done_idx = 2'h0;
    free_any = 1'b0;
    free_idx = 2'h0;
    next_any = 1'b0;
    next_idx = 2'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      slot_nxt[i] = slot_r[i];
      if (slot_r[i].valid && slot_r[i].count == 3'h1) begin
        done_any = 1'b1;
        done_idx = 2'(i);
      end
      if (!slot_r[i].valid) begin
        free_any = 1'b1;
        free_idx = 2'(i);
      end
      if (slot_r[i].valid && slot_r[i].count == 3'h2) begin
        next_any = 1'b1;
        next_idx = 2'(i);
      end
    end
    for (int i = 0; i < SLOTS; i++) begin
      if (slot_r[i].valid && !write_active) begin
        slot_nxt[i].count = slot_r[i].count - 3'h1; // R5 R18
        if (slot_r[i].count == 3'h1) begin
          slot_nxt[i].valid = 1'b0;
        end
      end
    end
    if (start && free_any) begin
      slot_nxt[free_idx].valid     = 1'b1; // R12 R13
      slot_nxt[free_idx].count     = read_latency_setting;
      slot_nxt[free_idx].addr      = addr;
      slot_nxt[free_idx].byte_mode = byte_mode;
    end
  end

  // byte or word selection of the returned data
  always_comb begin
    data_nxt = array_data;
    if (slot_r[done_idx].byte_mode) begin
      data_nxt = slot_r[done_idx].addr[BYTE_BIT] ?
        {{(DATA_WIDTH/2){1'b0}}, array_data[DATA_WIDTH-1:DATA_WIDTH/2]} :
        {{(DATA_WIDTH/2){1'b0}}, array_data[DATA_WIDTH/2-1:0]}; // R11
    end
  end

  // slot state; no edge means nothing moves
  always_ff @(posedge ref_clk) begin // R9
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_r[i] <= '0;
      end
    end else if (!write_active) begin // R4
      for (int i = 0; i < SLOTS; i++) begin
        slot_r[i] <= slot_nxt[i];
      end
    end
  end

  // latency setting register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_latency_setting <= LAT_RESET; // R6
    end else begin
      read_latency_setting <= lat_nxt; // R7
    end
  end

  // read data outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      read_data  <= '0;
      read_valid <= 1'b0;
    end else begin
      read_valid <= done_fire; // R5
      if (done_fire) begin
        read_data <= data_nxt;
      end
    end
  end

  // array port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      array_addr <= '0;
      array_bank <= 1'b0;
      array_rd   <= 1'b0;
    end else begin
      array_rd <= start_ok; // R1
      if (start_ok) begin
        array_bank <= addr[BANK_BIT]; // R10
      end
      if (addr_load) begin
        array_addr <= addr_next; // R10 R18
      end
    end
  end

  // assertions
  a_start_lat_ok: assert property (@(posedge ref_clk) disable iff (rst)
    (read_latency_setting >= LAT_MIN && read_latency_setting <= LAT_MAX))
    else $error("latency setting out of range"); // R8
  a_pd_resets_lat: assert property (@(posedge ref_clk) disable iff (rst)
    !powerdown_n |=> read_latency_setting == LAT_RESET)
    else $error("power-down exit did not restore latency"); // R6
  a_desel_no_rd: assert property (@(posedge ref_clk) disable iff (rst)
    (!chip_select || write_active) |=> !array_rd)
    else $error("read started while deselected or writing"); // R2
  a_write_no_rd: assert property (@(posedge ref_clk) disable iff (rst)
    write_active |=> !read_valid)
    else $error("read data during write"); // R4
  a_start_fires: assert property (@(posedge ref_clk) disable iff (rst)
    (start && free_any) |=> array_rd)
    else $error("accepted read not issued"); // R1
  a_lat_one: assert property (@(posedge ref_clk) disable iff (rst)
    (start && free_any && read_latency_setting == 3'h1 && !done_any)
    ##1 !write_active |=> read_valid)
    else $error("latency one data late"); // R5
  a_bank_follows: assert property (@(posedge ref_clk) disable iff (rst)
    (start && free_any) |=> array_bank == $past(addr[BANK_BIT]))
    else $error("bank bit not taken from address"); // R10
  a_sleep_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    (powerdown_n && !cfg_write) |=> $stable(read_latency_setting))
    else $error("latency changed without command"); // R7
  a_slots_count: assert property (@(posedge ref_clk) disable iff (rst)
    slot_r[0].valid |-> slot_r[0].count <= LAT_MAX)
    else $error("slot count beyond latency"); // R18

  // array port and start qualifiers
  a_adv_high_idle: assert property ( // R1
    @(posedge ref_clk) disable iff (rst)
    address_valid_n |=> !array_rd)
    else $error("read issued without strobe");

  a_rd_has_start: assert property ( // R1 R2
    @(posedge ref_clk) disable iff (rst)
    array_rd |-> $past(start_ok))
    else $error("array read without accepted start");

  a_full_refused: assert property ( // R12 R13
    @(posedge ref_clk) disable iff (rst)
    (start && !free_any) |=> !array_rd)
    else $error("read accepted with all slots busy");

  a_bank_held: assert property ( // R10
    @(posedge ref_clk) disable iff (rst)
    !start_ok |=> $stable(array_bank))
    else $error("bank changed without a start");

  a_addr_lat_one: assert property ( // R10
    @(posedge ref_clk) disable iff (rst)
    (start_ok && read_latency_setting == LAT_MIN)
    |=> array_addr == $past(addr[ADDR_WIDTH-1:1]))
    else $error("latency one address not presented");

  // latency setting
  a_cfg_applies: assert property ( // R8
    @(posedge ref_clk) disable iff (rst)
    (powerdown_n && cfg_ok)
    |=> read_latency_setting == $past(cfg_latency))
    else $error("configuration value not applied");

  a_cfg_bad_kept: assert property ( // R4 R8
    @(posedge ref_clk) disable iff (rst)
    (powerdown_n && cfg_write && !cfg_ok)
    |=> $stable(read_latency_setting))
    else $error("refused configuration changed latency");

  // completion and returned data
  a_valid_follows: assert property ( // R5
    @(posedge ref_clk) disable iff (rst)
    !write_active |=> read_valid == $past(done_any))
    else $error("read valid not on completion");

  a_data_from_slot: assert property ( // R10 R18
    @(posedge ref_clk) disable iff (rst)
    done_fire |-> array_addr == slot_r[done_idx].addr[ADDR_WIDTH-1:1])
    else $error("array address not of completing read");

  a_word_data: assert property ( // R11
    @(posedge ref_clk) disable iff (rst)
    (done_fire && !slot_r[done_idx].byte_mode)
    |=> read_data == $past(array_data))
    else $error("word read data wrong");

  a_byte_upper_zero: assert property ( // R11
    @(posedge ref_clk) disable iff (rst)
    (done_fire && slot_r[done_idx].byte_mode)
    |=> read_data[DATA_WIDTH-1:DATA_WIDTH/2] == '0)
    else $error("byte read upper half not zero");

  a_byte_low_lane: assert property ( // R11
    @(posedge ref_clk) disable iff (rst)
    (done_fire && slot_r[done_idx].byte_mode
     && !slot_r[done_idx].addr[BYTE_BIT])
    |=> read_data[DATA_WIDTH/2-1:0] == $past(array_data[DATA_WIDTH/2-1:0]))
    else $error("low byte lane wrong");

  a_byte_high_lane: assert property ( // R11
    @(posedge ref_clk) disable iff (rst)
    (done_fire && slot_r[done_idx].byte_mode
     && slot_r[done_idx].addr[BYTE_BIT])
    |=> read_data[DATA_WIDTH/2-1:0]
        == $past(array_data[DATA_WIDTH-1:DATA_WIDTH/2]))
    else $error("high byte lane wrong");

  // slots in flight
  a_start_count0: assert property ( // R18
    @(posedge ref_clk) disable iff (rst)
    (start_ok && free_idx == 2'h0)
    |=> slot_r[0].count == $past(read_latency_setting))
    else $error("slot count not loaded with latency");

  a_freeze_slot0: assert property ( // R4 R9
    @(posedge ref_clk) disable iff (rst)
    write_active |=> $stable(slot_r[0]))
    else $error("slot zero moved during write");

  a_freeze_slot1: assert property ( // R4 R9
    @(posedge ref_clk) disable iff (rst)
    write_active |=> $stable(slot_r[1]))
    else $error("slot one moved during write");

  a_freeze_slot2: assert property ( // R4 R9
    @(posedge ref_clk) disable iff (rst)
    write_active |=> $stable(slot_r[2]))
    else $error("slot two moved during write");

endmodule // spfr_read_pipe

// ### spfr_array_model.sv
// array word model feeding the read pipe
`timescale 1ns/100ps
module spfr_array_model
  import spfr_pkg::*;
(
  // array port
  input  wire logic [ADDR_W-2:0] array_addr,
  output logic      [DATA_W-1:0] array_data
);
  assign array_data = array_addr[15:0] ^ 16'hA5C3;
endmodule // spfr_array_model

// ### tb_top.sv
// self-checking bench for the pipelined flash read block
`timescale 1ns/100ps
module tb_top
  import spfr_pkg::*;
;
  logic ref_clk = 0, rst = 1, cs = 0, avn = 1, wr = 0, bm = 0, pd_n = 1;
  logic cfg_w = 0, run = 1, a_bank, a_rd, rv;
  logic [2:0] cfg_l = 3'h4, lat;
  logic [ADDR_W-1:0] addr = '0;
  logic [ADDR_W-2:0] a_addr;
  logic [DATA_W-1:0] a_data, rd;
  logic [16:0] d;
  logic [15:0] lf = 16'h3966;
  int err_count = 0, n_tests = 0, cyc = 0, cur_l = 4;
  int exp_q[$];
  logic [16:0] dat_q[$];
  spfr_read_pipe dut (.ref_clk(ref_clk), .rst(rst), .chip_select(cs),
    .address_valid_n(avn), .write_active(wr), .byte_mode(bm), .addr(addr),
    .powerdown_n(pd_n), .cfg_write(cfg_w), .cfg_latency(cfg_l),
    .array_addr(a_addr), .array_bank(a_bank), .array_rd(a_rd),
    .array_data(a_data), .read_data(rd), .read_valid(rv),
    .read_latency_setting(lat));
  spfr_array_model arr (.array_addr(a_addr), .array_data(a_data));
  initial forever begin
    #50;
    if (run) ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    if (seen !== exp) begin
      $display("mismatch at %0t: %0h vs %0h", $time, seen, exp);
      err_count++;
    end
    n_tests++;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one strobe; k marks a read whose data is compared
  task automatic go(input logic [ADDR_W-1:0] a, input logic b, input logic k);
    logic [15:0] w;
    @(posedge ref_clk);
    addr <= a;
    bm <= b;
    avn <= 1'b0;
    w = a[16:1] ^ 16'hA5C3;
    exp_q.push_back(cyc + 2 + cur_l);
    dat_q.push_back({k, b ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w});
    @(posedge ref_clk);
    avn <= 1'b1;
    @(negedge ref_clk);
    chk(a_rd, 1);
    chk(a_bank, a[1]);
  endtask
  task automatic setl(input logic [2:0] v);
    @(posedge ref_clk);
    cfg_w <= 1'b1;
    cfg_l <= v;
    @(posedge ref_clk);
    cfg_w <= 1'b0;
    @(negedge ref_clk);
  endtask
  always @(negedge ref_clk) if (rv === 1'b1) begin
    if (exp_q.size() == 0) chk(1, 0);
    else begin
      chk(cyc, exp_q.pop_front());
      d = dat_q.pop_front();
      if (d[16]) chk(rd, d[15:0]);
    end
  end
  task automatic end_of_test;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
  initial begin
    idle(20);
    rst <= 1'b0;
    cs <= 1'b1;
    @(negedge ref_clk);
    chk(lat, 4);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      go({lf[4:0], lf}, lf[7], 1'b1);
      idle(6);
    end
    go(21'h000000, 0, 1);
    go(21'h000002, 0, 1);
    go(21'h000004, 0, 1);
    idle(8);
    go(21'h000010, 0, 1);
    idle(2);
    go(21'h000011, 1, 1);
    idle(8);
    $display("test random and overlap done");
    for (int v = 0; v < 6; v++) begin
      setl(v[2:0]);
      if (v >= 1 && v <= 4) cur_l = v;
      chk(lat, cur_l);
      go({lf[4:0], lf}, v[0], 1'b1);
      idle(6);
    end
    setl(3'h2);
    cur_l = 2;
    go(21'h0ABCD4, 0, 1);
    exp_q[0] += 3;
    @(posedge ref_clk);
    wr <= 1'b1;
    avn <= 1'b0;
    idle(3);
    wr <= 1'b0;
    avn <= 1'b1;
    idle(6);
    @(posedge ref_clk);
    cs <= 1'b0;
    avn <= 1'b0;
    @(posedge ref_clk);
    cs <= 1'b1;
    avn <= 1'b1;
    idle(6);
    go(21'h1F0F0F, 1, 1);
    run = 1'b0;
    #1000;
    run = 1'b1;
    idle(6);
    $display("test write deselect clock done");
    @(posedge ref_clk);
    pd_n <= 1'b0;
    @(posedge ref_clk);
    pd_n <= 1'b1;
    @(negedge ref_clk);
    chk(lat, 4);
    chk(exp_q.size(), 0);
    $display("test powerdown done");
    end_of_test;
  end
endmodule // tb_top
